/* pcfx_card.sv */
// Card end: answer timing and frame shaping
`timescale 1ns/1ps
module pcfx_card #(
  parameter int unsigned FDT_N = pcfx_pkg::FDT_N_DEF
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Link
  pcfx_if.card lnk,
  // Answer byte stream
  input wire logic ans_valid,
  input wire logic [7:0] ans_data,
  input wire logic ans_last,
  output logic ans_ready_q,
  // Received frame report
  output logic rx_done_q,
  output pcfx_pkg::pcfx_cmd_t rx_cmd_q,
  output logic rx_last_q,
  output logic busy_q
);
  typedef enum logic [2:0] {
    C_IDLE, C_WAIT, C_LEAD, C_SOFL, C_SOFH, C_DATA, C_EOF
  } pcfx_cst_t;

  localparam int unsigned CW = pcfx_pkg::CARD_CNT_W;
  localparam logic [CW-1:0] ETU_LAST =
    CW'(pcfx_pkg::FC_PER_ETU - 1);
  localparam logic [CW-1:0] LEAD_LAST =
    CW'(pcfx_pkg::TR1_FS * pcfx_pkg::FC_PER_FS - 1);
  localparam logic [CW-1:0] SOFL_LAST =
    CW'(pcfx_pkg::SOF_LOW_ETU * pcfx_pkg::FC_PER_ETU - 1);
  localparam logic [CW-1:0] SOFH_LAST =
    CW'(pcfx_pkg::SOF_HIGH_ETU * pcfx_pkg::FC_PER_ETU - 1);
  localparam logic [CW-1:0] EOF_LAST =
    CW'(pcfx_pkg::EOF_LOW_ETU * pcfx_pkg::FC_PER_ETU - 1);
  localparam logic [CW-1:0] TR0_LAST =
    CW'(pcfx_pkg::TR0_FS * pcfx_pkg::FC_PER_FS - 1);
  localparam logic [CW-1:0] FDT_BASE =
    CW'(FDT_N * pcfx_pkg::FC_PER_ETU);
  localparam logic [6:0] LOSS_LAST = 7'(pcfx_pkg::LOSS_CLK - 1);

  // Pin synchronisers: frame, bit, command, carrier
  logic [4:0] s1_q, s2_q;
  logic fr3_q, car3_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
      fr3_q <= 1'b0;
      car3_q <= 1'b0;
    end else begin
      s1_q <= {lnk.carrier, lnk.rd_frame, lnk.rd_bit, lnk.rd_cmd};
      s2_q <= s1_q;
      fr3_q <= s2_q[3];
      car3_q <= s2_q[4];
    end
  end

  logic tick, fr_s, fr_fall, bit_s;
  pcfx_pkg::pcfx_cmd_t cmd_s;
  assign tick = s2_q[4] & ~car3_q; // Carrier rising edge
  assign fr_s = s2_q[3];
  assign fr_fall = fr3_q & ~s2_q[3];
  assign bit_s = s2_q[2];
  assign cmd_s = pcfx_pkg::pcfx_cmd_t'(s2_q[1:0]);

  // Frame state
  pcfx_cst_t st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d, wait_last;
  logic [9:0] sh_q, sh_d;
  logic [3:0] bi_q, bi_d, nb_last;
  logic bmode_q, bmode_d, end_q, end_d, lbit_q, lbit_d;
  logic sub_q, sub_d, mod_q, mod_d;
  logic [6:0] loss_q, loss_d;
  logic ans_ready_d, rx_done_d, busy_d, load;
  pcfx_pkg::pcfx_cmd_t cmd_q, cmd_d;

  // Silence before the answer, picked by command class
  always_comb begin
    if (bmode_q) begin
      wait_last = TR0_LAST;
    end else if (cmd_q == pcfx_pkg::PCFX_CMD_SHORT) begin
      wait_last = lbit_q ? CW'(pcfx_pkg::FDT_SHORT_ONE_FC - 1)
                         : CW'(pcfx_pkg::FDT_SHORT_ZERO_FC - 1);
    end else begin
      wait_last = lbit_q ? FDT_BASE + CW'(pcfx_pkg::FDT_ONE_ADD_FC - 1)
                         : FDT_BASE + CW'(pcfx_pkg::FDT_ZERO_ADD_FC - 1);
    end
  end

  assign nb_last = bmode_q ? 4'(pcfx_pkg::CHAR_B_BITS - 1)
                           : 4'(pcfx_pkg::CHAR_A_BITS - 1);

  // Next state of the answer sequencer
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    bi_d = bi_q;
    bmode_d = bmode_q;
    end_d = end_q;
    lbit_d = lbit_q;
    cmd_d = cmd_q;
    sub_d = sub_q;
    mod_d = mod_q;
    ans_ready_d = 1'b0;
    rx_done_d = 1'b0;
    load = 1'b0;
    loss_d = tick ? 7'h00 : loss_q;
    if (!tick && loss_q != LOSS_LAST) begin
      loss_d = loss_q + 7'h01;
    end
    if (tick) begin
      cnt_d = cnt_q + CW'(1);
    end
    case (st_q)
      C_IDLE: begin
        sub_d = 1'b0;
        mod_d = pcfx_pkg::IDLE_MOD;
        if (fr_s) begin
          lbit_d = bit_s;
          cmd_d = cmd_s;
        end
        if (fr_fall) begin
          rx_done_d = 1'b1;
          cnt_d = '0;
          end_d = 1'b0;
          bmode_d = (cmd_q == pcfx_pkg::PCFX_CMD_ATQB) ||
                    (cmd_q == pcfx_pkg::PCFX_CMD_DEACT);
          st_d = C_WAIT;
        end
      end
      C_WAIT: begin
        if (tick && cnt_q == wait_last) begin
          if (bmode_q) begin
            st_d = C_LEAD;
            cnt_d = '0;
            sub_d = 1'b1; // Plain subcarrier lead
          end else begin
            load = 1'b1;
          end
        end
      end
      C_LEAD: begin
        if (tick && cnt_q == LEAD_LAST) begin
          st_d = C_SOFL;
          cnt_d = '0;
          mod_d = 1'b0;
        end
      end
      C_SOFL: begin
        if (tick && cnt_q == SOFL_LAST) begin
          st_d = C_SOFH;
          cnt_d = '0;
          mod_d = 1'b1;
        end
      end
      C_SOFH: begin
        load = tick && cnt_q == SOFH_LAST;
      end
      C_DATA: begin
        if (tick && cnt_q == ETU_LAST) begin // Whole etu per bit
          cnt_d = '0;
          if (bi_q == nb_last) begin
            load = 1'b1; // Next character at once, no guard
          end else begin
            bi_d = bi_q + 4'h1;
            sh_d = {1'b0, sh_q[9:1]};
            mod_d = sh_q[1];
          end
        end
      end
      C_EOF: begin
        if (tick && cnt_q == EOF_LAST) begin
          st_d = C_IDLE;
          sub_d = 1'b0; // Off on the same edge
          mod_d = pcfx_pkg::IDLE_MOD;
        end
      end
      default: begin
        st_d = C_IDLE;
      end
    endcase
    // Take the next byte or close the frame
    if (load) begin
      cnt_d = '0;
      bi_d = 4'h0;
      if (ans_valid && !end_q) begin
        sh_d = bmode_q ? {1'b1, ans_data, 1'b0}
                       : {1'b0, ~^ans_data, ans_data};
        ans_ready_d = 1'b1;
        end_d = ans_last;
        st_d = C_DATA;
        sub_d = 1'b1;
        mod_d = sh_d[0];
      end else if (bmode_q) begin
        st_d = C_EOF;
        mod_d = 1'b0;
      end else begin
        st_d = C_IDLE;
        sub_d = 1'b0;
        mod_d = pcfx_pkg::IDLE_MOD;
      end
    end
    // Carrier gone: the card falls back to idle
    if (loss_q == LOSS_LAST) begin
      st_d = C_IDLE;
      sub_d = 1'b0;
      mod_d = pcfx_pkg::IDLE_MOD;
    end
    busy_d = (st_d != C_IDLE);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= C_IDLE;
      cnt_q <= '0;
      sh_q <= 10'h000;
      bi_q <= 4'h0;
      bmode_q <= 1'b0;
      end_q <= 1'b0;
      lbit_q <= 1'b0;
      cmd_q <= pcfx_pkg::PCFX_CMD_SHORT;
      sub_q <= 1'b0;
      mod_q <= pcfx_pkg::IDLE_MOD;
      loss_q <= 7'h00;
      ans_ready_q <= 1'b0;
      rx_done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      bi_q <= bi_d;
      bmode_q <= bmode_d;
      end_q <= end_d;
      lbit_q <= lbit_d;
      cmd_q <= cmd_d;
      sub_q <= sub_d;
      mod_q <= mod_d;
      loss_q <= loss_d;
      ans_ready_q <= ans_ready_d;
      rx_done_q <= rx_done_d;
      busy_q <= busy_d;
    end
  end

  // Report and pins straight from flops
  assign rx_cmd_q = cmd_q;
  assign rx_last_q = lbit_q;
  assign lnk.card_sub = sub_q;
  assign lnk.card_mod = mod_q;
endmodule // pcfx_card

/* pcfx_pkg.sv */
// Shared constants and types for the proximity frame timing link
package pcfx_pkg;

  // Command classes carried beside the reader frame
  typedef enum logic [1:0] {
    PCFX_CMD_SHORT,
    PCFX_CMD_OTHER,
    PCFX_CMD_ATQB,
    PCFX_CMD_DEACT
  } pcfx_cmd_t;

  // Carrier based units
  localparam int unsigned FC_PER_ETU = 128;
  localparam int unsigned FC_PER_FS = 16;
  // Frame delay, short commands
  localparam int unsigned FDT_SHORT_ONE_FC = 1236;
  localparam int unsigned FDT_SHORT_ZERO_FC = 1172;
  // Frame delay, other commands: n * etu + offset
  localparam int unsigned FDT_ONE_ADD_FC = 84;
  localparam int unsigned FDT_ZERO_ADD_FC = 20;
  localparam int unsigned FDT_N_DEF = 9;
  // Reader guard between request frames
  localparam int unsigned GUARD_FC = 7000;
  // Card frame phases
  localparam int unsigned SOF_LOW_ETU = 10;
  localparam int unsigned SOF_HIGH_ETU = 2;
  localparam int unsigned EOF_LOW_ETU = 10;
  localparam int unsigned TR0_FS = 64;
  localparam int unsigned TR1_FS = 80;
  localparam int unsigned DEACT_MAX_FS = 65536;
  // Character lengths: A has 8 data plus parity, B start/8/stop
  localparam int unsigned CHAR_A_BITS = 9;
  localparam int unsigned CHAR_B_BITS = 10;
  // Counter widths
  localparam int unsigned CARD_CNT_W = 12;
  localparam int unsigned RDR_CNT_W = 21;
  // Core clock and carrier synthesis
  localparam int unsigned CORE_CLK_HZ = 25000000;
  // Two core clocks per half carrier keeps each level two samples wide
  localparam int unsigned CARRIER_HALF_CLK = 2;
  localparam int unsigned LOSS_CLK = 64;
  localparam int unsigned OFF_CLK = 2048;
  // Reset values
  localparam logic IDLE_MOD = 1'b1;

endpackage

/* pcfx_if.sv */
// Link wires between reader and card
`timescale 1ns/1ps
interface pcfx_if;
  logic carrier;
  logic rd_frame;
  logic rd_bit;
  pcfx_pkg::pcfx_cmd_t rd_cmd;
  logic card_sub;
  logic card_mod;

  modport reader (
    output carrier,
    output rd_frame,
    output rd_bit,
    output rd_cmd,
    input card_sub,
    input card_mod
  );

  modport card (
    input carrier,
    input rd_frame,
    input rd_bit,
    input rd_cmd,
    output card_sub,
    output card_mod
  );
endinterface

/* pcfx_reader.sv */
// Reader end: carrier, request frames, answer wait and retry
`timescale 1ns/1ps
module pcfx_reader #(
  parameter int unsigned GUARD = pcfx_pkg::GUARD_FC,
  parameter int unsigned RSP_TIMEOUT =
    pcfx_pkg::DEACT_MAX_FS * pcfx_pkg::FC_PER_FS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Link
  pcfx_if.reader lnk,
  // Request
  input wire logic start,
  input wire pcfx_pkg::pcfx_cmd_t cmd,
  input wire logic [4:0] nbits,
  input wire logic [15:0] bits,
  // Results
  output logic busy_q,
  output logic answered_q,
  output logic [pcfx_pkg::RDR_CNT_W-1:0] lat_q,
  output logic done_q,
  output logic timeout_q,
  output logic retry_q
);
  typedef enum logic [2:0] {R_IDLE, R_SEND, R_WAIT, R_RX, R_OFF} pcfx_rst_t;

  localparam int unsigned RW = pcfx_pkg::RDR_CNT_W;
  localparam logic [2:0] HALF_LAST = 3'(pcfx_pkg::CARRIER_HALF_CLK - 1);
  localparam logic [RW-1:0] ETU_LAST = RW'(pcfx_pkg::FC_PER_ETU - 1);
  localparam logic [RW-1:0] TMO_LAST = RW'(RSP_TIMEOUT - 1);
  localparam logic [RW-1:0] OFF_LAST = RW'(pcfx_pkg::OFF_CLK - 1);
  localparam logic [12:0] GUARD_N = 13'(GUARD);

  // Answer pin synchroniser
  logic sub1_q, sub2_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sub1_q <= 1'b0;
      sub2_q <= 1'b0;
    end else begin
      sub1_q <= lnk.card_sub;
      sub2_q <= sub1_q;
    end
  end

  pcfx_rst_t st_q, st_d;
  logic [2:0] div_q, div_d;
  logic car_q, car_d, tick;
  logic [RW-1:0] cnt_q, cnt_d, lat_d;
  logic [12:0] gd_q, gd_d;
  logic [15:0] sh_q, sh_d;
  logic [4:0] bi_q, bi_d, nb_q, nb_d;
  logic fr_q, fr_d, bit_q, bit_d;
  logic ans_d, done_d, tmo_d, retry_d, busy_d;
  pcfx_pkg::pcfx_cmd_t cmd_q, cmd_d;

  // Carrier divider: one carrier cycle per 2*HALF core clocks
  assign tick = (div_q == HALF_LAST) && !car_q && (st_q != R_OFF);

  // Next state of the reader sequencer
  always_comb begin
    st_d = st_q;
    div_d = (div_q == HALF_LAST) ? 3'h0 : div_q + 3'h1;
    car_d = car_q;
    if (div_q == HALF_LAST) begin
      car_d = ~car_q;
    end
    cnt_d = tick ? cnt_q + RW'(1) : cnt_q;
    gd_d = (tick && gd_q != GUARD_N) ? gd_q + 13'h0001 : gd_q;
    lat_d = lat_q;
    sh_d = sh_q;
    bi_d = bi_q;
    nb_d = nb_q;
    fr_d = fr_q;
    bit_d = bit_q;
    cmd_d = cmd_q;
    ans_d = 1'b0;
    done_d = 1'b0;
    tmo_d = 1'b0;
    retry_d = 1'b0;
    case (st_q)
      R_IDLE: begin
        if (start && nbits != 5'h00 && gd_q == GUARD_N) begin
          st_d = R_SEND;
          sh_d = bits;
          nb_d = nbits;
          bi_d = 5'h00;
          cmd_d = cmd;
          fr_d = 1'b1;
          bit_d = bits[0];
          cnt_d = '0;
        end
      end
      R_SEND: begin
        if (tick && cnt_q == ETU_LAST) begin
          cnt_d = '0;
          if (bi_q == nb_q - 5'h01) begin
            st_d = R_WAIT;
            fr_d = 1'b0;
            gd_d = 13'h0000;
          end else begin
            bi_d = bi_q + 5'h01;
            sh_d = {1'b0, sh_q[15:1]};
            bit_d = sh_q[1];
          end
        end
      end
      R_WAIT, R_RX: begin
        if (st_q == R_WAIT && sub2_q) begin
          st_d = R_RX;
          ans_d = 1'b1;
          lat_d = cnt_q;
        end else if (st_q == R_RX && !sub2_q) begin
          st_d = R_IDLE;
          done_d = 1'b1;
          gd_d = 13'h0000;
        end else if (tick && cnt_q == TMO_LAST) begin
          st_d = R_OFF; // Silent card: cycle the carrier
          tmo_d = 1'b1;
          cnt_d = '0;
        end
      end
      R_OFF: begin
        car_d = 1'b0;
        cnt_d = cnt_q + RW'(1);
        if (cnt_q == OFF_LAST) begin
          st_d = R_IDLE;
          retry_d = 1'b1; // Carrier back, user may resend
          gd_d = 13'h0000;
        end
      end
      default: begin
        st_d = R_IDLE;
      end
    endcase
    busy_d = (st_d != R_IDLE) || (gd_d != GUARD_N);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= R_IDLE;
      div_q <= 3'h0;
      car_q <= 1'b0;
      cnt_q <= '0;
      gd_q <= GUARD_N; // Full so the first start is taken at once
      lat_q <= '0;
      sh_q <= 16'h0000;
      bi_q <= 5'h00;
      nb_q <= 5'h00;
      fr_q <= 1'b0;
      bit_q <= 1'b0;
      cmd_q <= pcfx_pkg::PCFX_CMD_SHORT;
      answered_q <= 1'b0;
      done_q <= 1'b0;
      timeout_q <= 1'b0;
      retry_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      car_q <= car_d;
      cnt_q <= cnt_d;
      gd_q <= gd_d;
      lat_q <= lat_d;
      sh_q <= sh_d;
      bi_q <= bi_d;
      nb_q <= nb_d;
      fr_q <= fr_d;
      bit_q <= bit_d;
      cmd_q <= cmd_d;
      answered_q <= ans_d;
      done_q <= done_d;
      timeout_q <= tmo_d;
      retry_q <= retry_d;
      busy_q <= busy_d;
    end
  end

  // Link pins straight from flops
  assign lnk.carrier = car_q;
  assign lnk.rd_frame = fr_q;
  assign lnk.rd_bit = bit_q;
  assign lnk.rd_cmd = cmd_q;
endmodule // pcfx_reader

/* pcfx_chk.sv */
// Link timing checker for the reader to card frame link
`timescale 1ns/1ps
module pcfx_chk #(
  parameter int unsigned GUARD = pcfx_pkg::GUARD_FC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Link
  input wire logic carrier,
  input wire logic rd_frame,
  input wire logic rd_bit,
  input wire pcfx_pkg::pcfx_cmd_t rd_cmd,
  input wire logic card_sub,
  input wire logic card_mod
);
  logic car_q, mod_q, sub_q, last_q, last_d, sof_q, sof_d, eof_q, eof_d;
  logic hi_q, hi_d, tick, long_lo, mod_dn, first_dn;
  logic [20:0] gap_q, gap_d, run_q, run_d, eofc_q, eofc_d, idle_q, idle_d;
  assign tick = carrier & ~car_q;
  assign long_lo = card_mod && !mod_q && sub_q && run_q > 21'd1216;
  assign mod_dn = !card_mod && mod_q && card_sub;
  assign first_dn = mod_dn && !sof_q && rd_cmd[1];
  // Carrier ticks are the time base; phases counted in fc
  always_comb begin
    gap_d = rd_frame ? '0 : gap_q + 21'(tick);
    run_d = (!card_sub || card_mod != mod_q) ? '0 : run_q + 21'(tick);
    last_d = rd_frame ? rd_bit : last_q;
    sof_d = card_sub && (sof_q || long_lo);
    eof_d = card_sub && (eof_q || (long_lo && sof_q));
    hi_d = card_sub && (long_lo || (hi_q && !mod_dn));
    eofc_d = eof_q ? eofc_q + 21'(tick) : '0;
    // Saturates so a long idle never wraps into a false guard error
    idle_d = (rd_frame || card_sub) ? '0 : idle_q + 21'(tick && !idle_q[20]);
  end
  // Registers; idle starts full as the reader may start at once
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {car_q, mod_q, sub_q, last_q, sof_q, eof_q, hi_q} <= 7'h20;
      {gap_q, run_q, eofc_q} <= '0;
      idle_q <= '1;
    end else begin
      {car_q, mod_q, sub_q} <= {carrier, card_mod, card_sub};
      {last_q, sof_q, eof_q, hi_q} <= {last_d, sof_d, eof_d, hi_d};
      {gap_q, run_q, eofc_q, idle_q} <= {gap_d, run_d, eofc_d, idle_d};
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_fdt_short: assert property (
    card_sub && !sub_q && rd_cmd == pcfx_pkg::PCFX_CMD_SHORT |->
    (last_q ? gap_q inside {[1235:1238]} : gap_q inside {[1171:1174]}))
    else $error("short command answer delay wrong");
  a_fdt_other: assert property (
    card_sub && !sub_q && rd_cmd == pcfx_pkg::PCFX_CMD_OTHER |->
    (last_q ? gap_q[6:0] inside {[83:86]} : gap_q[6:0] inside {[19:22]}))
    else $error("other command answer delay off grid");
  a_guard_gap: assert property ($rose(rd_frame) |-> idle_q >= GUARD - 2)
    else $error("request frames too close");
  a_frame_low: assert property (long_lo |-> run_q inside {[1279:1409]})
    else $error("start or end low phase length wrong");
  a_sof_high: assert property (hi_q && mod_dn |-> run_q inside {[255:385]})
    else $error("start high phase length wrong");
  a_bit_grid: assert property (
    card_sub && sub_q && card_mod != mod_q |->
    run_q[6:0] <= 7'd16 || run_q[6:0] >= 7'd112)
    else $error("card bit edge off the etu grid");
  a_tr_zero: assert property (
    card_sub && !sub_q && rd_cmd == pcfx_pkg::PCFX_CMD_ATQB |->
    gap_q inside {[1023:4098]})
    else $error("silent time before subcarrier wrong");
  a_tr_one: assert property (first_dn |-> run_q inside {[1279:3201]})
    else $error("plain subcarrier time wrong");
  a_sub_off: assert property (eof_q |-> eofc_q <= 21'd257)
    else $error("subcarrier kept after end of frame");
  a_deact_win: assert property (
    first_dn && rd_cmd == pcfx_pkg::PCFX_CMD_DEACT |->
    gap_q inside {[2303:1048578]})
    else $error("deactivation answer outside window");
  c_short: cover property (card_sub && !sub_q && !rd_cmd[1]);
  c_eof: cover property (long_lo && sof_q);
  c_deact: cover property (first_dn && rd_cmd == pcfx_pkg::PCFX_CMD_DEACT);
endmodule // pcfx_chk

/* contactless_card_frame_timing_tb.sv */
// Bench: reader and card over the link, plus a reader facing a mute card
`timescale 1ns/1ps
module contactless_card_frame_timing_tb;
  localparam int unsigned GUARD = 200;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic start2 = 1'b0;
  pcfx_pkg::pcfx_cmd_t cmd = pcfx_pkg::PCFX_CMD_SHORT;
  logic [4:0] nbits = 5'h1;
  logic [15:0] bits = 16'h0000;
  logic busy, answered, done, tmo2, retry2, ans_valid, ans_last;
  logic ans_ready, rx_last, rx_done, cbusy;
  logic [7:0] ans_data;
  logic [pcfx_pkg::RDR_CNT_W-1:0] lat;
  pcfx_pkg::pcfx_cmd_t rx_cmd;
  int failures = 0, check_count = 0, cyc = 0, nb = 0, idx = 0, sub_len = 0;
  pcfx_if lnk ();
  pcfx_if lnk2 ();
  // Mute card: subcarrier off, no modulation
  assign lnk2.card_sub = 1'b0;
  assign lnk2.card_mod = 1'b1;
  assign ans_valid = idx < nb;
  assign ans_last = idx == nb - 1;
  assign ans_data = 8'(idx) ^ 8'ha5;
  // Timeout above the longest answer delay plus framed answer, 6400 fc
  pcfx_reader #(.GUARD(GUARD), .RSP_TIMEOUT(8000)) u_pcfx_reader (
    .core_clk, .rst, .lnk(lnk.reader), .start, .cmd, .nbits, .bits,
    .busy_q(busy), .answered_q(answered), .lat_q(lat), .done_q(done),
    .timeout_q(), .retry_q());
  pcfx_reader #(.GUARD(GUARD), .RSP_TIMEOUT(2000)) u_pcfx_reader_mute (
    .core_clk, .rst, .lnk(lnk2.reader), .start(start2),
    .cmd(pcfx_pkg::PCFX_CMD_SHORT), .nbits(5'h1), .bits(16'h0001),
    .busy_q(), .answered_q(), .lat_q(), .done_q(), .timeout_q(tmo2),
    .retry_q(retry2));
  pcfx_card #(.FDT_N(5)) u_pcfx_card (
    .core_clk, .rst, .lnk(lnk.card), .ans_valid, .ans_data, .ans_last,
    .ans_ready_q(ans_ready), .rx_done_q(rx_done), .rx_cmd_q(rx_cmd),
    .rx_last_q(rx_last), .busy_q(cbusy));
  pcfx_chk #(.GUARD(GUARD)) u_pcfx_chk (
    .core_clk, .rst, .carrier(lnk.carrier), .rd_frame(lnk.rd_frame),
    .rd_bit(lnk.rd_bit), .rd_cmd(lnk.rd_cmd), .card_sub(lnk.card_sub),
    .card_mod(lnk.card_mod));
  always #20 core_clk = ~core_clk;
  // Byte stream steps on each accepted byte
  always @(posedge core_clk) if (ans_ready) idx <= idx + 1;
  // Subcarrier length in fc, watched on the wire itself
  always @(posedge lnk.carrier) if (lnk.card_sub) sub_len <= sub_len + 1;
  // Watchdog sized for six exchanges at 4 clocks per fc
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got,
    input int lo, input int hi);
    check_count++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      failures++;
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  // Pulses are looked at on the falling edge, once settled
  task automatic wait_hi(ref logic sig, input string nm, input int lim);
    int w;
    w = 0;
    while (sig !== 1'b1 && w < lim) begin
      @(negedge core_clk);
      w++;
    end
    chk(nm, {31'h0, sig}, 1, 1);
  endtask
  // One request and its answer; next start comes as soon as busy drops
  task automatic xfer(input pcfx_pkg::pcfx_cmd_t c, input logic [4:0] n,
    input logic [15:0] b, input int nby, input int lat_x, input int len_x);
    int w;
    @(posedge core_clk);
    cmd <= c;
    nbits <= n;
    bits <= b;
    nb <= nby;
    idx <= 0;
    sub_len <= 0;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    wait_hi(rx_done, "rx_done", 20000);
    wait_hi(answered, "answered", 20000);
    chk("latency", {11'h0, lat}, lat_x - 1, lat_x + 3);
    wait_hi(done, "done", 60000);
    chk("rx_cmd", {30'h0, rx_cmd}, c, c);
    chk("rx_last", {31'h0, rx_last}, b[n-1], b[n-1]);
    chk("sub_len", sub_len, len_x - 2, len_x + 2);
    chk("card_busy", {31'h0, cbusy}, 0, 0);
    w = 0;
    while (busy !== 1'b0 && w < 4000) begin
      @(negedge core_clk);
      w++;
    end
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    fork
      begin : mute_side
        logic seen;
        @(posedge core_clk);
        start2 <= 1'b1;
        @(posedge core_clk);
        start2 <= 1'b0;
        wait_hi(tmo2, "timeout", 40000);
        seen = 1'b0;
        repeat (16) begin
          @(negedge core_clk);
          seen = seen | lnk2.carrier;
        end
        chk("carrier_off", {31'h0, seen}, 0, 0);
        wait_hi(retry2, "retry", 4000);
      end
      begin
        xfer(pcfx_pkg::PCFX_CMD_SHORT, 5'h1, 16'h0001, 1, 1236, 1152);
        xfer(pcfx_pkg::PCFX_CMD_SHORT, 5'h2, 16'h0001, 1, 1172, 1152);
        xfer(pcfx_pkg::PCFX_CMD_OTHER, 5'h8, 16'h0080, 1, 724, 1152);
        xfer(pcfx_pkg::PCFX_CMD_OTHER, 5'h1, 16'h0000, 1, 660, 1152);
        xfer(pcfx_pkg::PCFX_CMD_ATQB, 5'h1, 16'h0001, 1, 1024, 5376);
        xfer(pcfx_pkg::PCFX_CMD_DEACT, 5'h1, 16'h0000, 0, 1024, 4096);
      end
    join
    report_and_stop();
  end
endmodule // contactless_card_frame_timing_tb
